// ---- inc/dsp_mac_pkg.sv ----
package dsp_mac_pkg;
    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int DWORD_W = 64;
    localparam int ACC_W = 66;
    localparam int FCR_OVF_DISABLE_BIT = 16;
    localparam int FFT_SHIFT = 15;
    localparam int RESULT_LATENCY = 2;
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

    typedef enum logic [3:0] {
        mul_word,
        mul_unsigned_double,
        mul_signed_double,
        mac_word,
        mac_double,
        msub_word,
        msub_double,
        half_mac_word,
        half_mac_double,
        complex_multiply,
        complex_multiply_add,
        complex_add_subtract,
        butterfly_add_subtract
    } dsp_op_type;

    function automatic logic writes_high(input dsp_op_type op);
        return !(op inside {mul_word, mac_word, msub_word, half_mac_word});
    endfunction : writes_high

    function automatic logic signed [ACC_W-1:0] sx16(input logic [15:0] x);
        return {{(ACC_W-HALF_W){x[15]}}, x};
    endfunction : sx16

    function automatic logic signed [ACC_W-1:0] sx32(input logic [31:0] x);
        return {{(ACC_W-WORD_W){x[31]}}, x};
    endfunction : sx32

    function automatic logic signed [ACC_W-1:0] sx64(input logic [63:0] x);
        return {{(ACC_W-DWORD_W){x[63]}}, x};
    endfunction : sx64
endpackage : dsp_mac_pkg

// ---- inc/mac_stage_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface mac_stage_if;
    import dsp_mac_pkg::*;
    logic valid;
    dsp_op_type op;
    logic [15:0] ld_hi;
    logic [15:0] ld_lo;
    logic [63:0] prod;
    logic [31:0] hh;
    logic [31:0] ll;
    logic [31:0] hl;
    logic [31:0] lh;
    logic ovf_enable;

    modport producer (
        output valid, op, ld_hi, ld_lo, prod, hh, ll, hl, lh, ovf_enable
    );
    modport consumer (
        input valid, op, ld_hi, ld_lo, prod, hh, ll, hl, lh, ovf_enable
    );
endinterface : mac_stage_if
`default_nettype wire

// ---- rtl/dsp_multiply_accumulate_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsp_multiply_accumulate_unit (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Issue from the instruction pipeline
    input wire logic issue_valid,
    input wire dsp_mac_pkg::dsp_op_type issue_op,
    input wire logic [31:0] dest_operand_reg,
    input wire logic [31:0] src_operand_reg,
    // Function control register as held by the processor
    input wire logic [31:0] function_control_reg,
    // Ordinary register file writes to the result registers
    input wire logic gwr_high_en,
    input wire logic gwr_low_en,
    input wire logic [31:0] gwr_data,
    // Result registers
    output logic [31:0] high_result_reg,
    output logic [31:0] low_result_reg,
    // Interlock status
    output logic low_pending,
    output logic pair_pending,
    // Extended overflow exception
    output logic ext_overflow_req,
    input wire logic ext_overflow_ack
);
    import dsp_mac_pkg::*;

    mac_stage_if st ();

    logic [31:0] high_r;
    logic [31:0] low_r;
    logic low_pending_r;
    logic pair_pending_r;

    logic [31:0] high_nxt;
    logic [31:0] low_nxt;
    logic wr_high;
    logic wr_low;
    logic ovf_hit;
    logic ovf_event;

    logic signed [ACC_W-1:0] acc_low;
    logic signed [ACC_W-1:0] acc_pair;
    logic signed [ACC_W-1:0] prod_s;
    logic signed [ACC_W-1:0] half_sum;
    logic signed [ACC_W-1:0] real_part;
    logic signed [ACC_W-1:0] imag_part;
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] term_high;
    logic signed [ACC_W-1:0] term_low;
    logic signed [ACC_W-1:0] sum_hi;
    logic signed [ACC_W-1:0] sum_lo;
    logic signed [ACC_W-1:0] dif_hi;
    logic signed [ACC_W-1:0] dif_lo;

    // True when v is representable as a signed w-bit value
    function automatic logic fits(
        input logic signed [ACC_W-1:0] v,
        input int w
    );
        logic signed [ACC_W-1:0] lim;
        lim = {{(ACC_W-1){1'b0}}, 1'b1} <<< (w - 1);
        return (v >= -lim) && (v < lim);
    endfunction : fits

    // Products are taken from the operands at issue
    mac_products u_products (
        .clk(clk),
        .rstn(rstn),
        .issue_valid(issue_valid),
        .issue_op(issue_op),
        .dest_operand_reg(dest_operand_reg),
        .src_operand_reg(src_operand_reg),
        .ovf_enable(~function_control_reg[FCR_OVF_DISABLE_BIT]),
        .st(st.producer)
    );

    // Accumulator views of the current result registers and the staged products
    assign acc_low = sx32(low_r);
    assign acc_pair = sx64({high_r, low_r});
    assign prod_s = sx64(st.prod);
    assign half_sum = sx32(st.hh) + sx32(st.ll);
    assign real_part = sx32(st.hh) - sx32(st.ll);
    assign imag_part = sx32(st.hl) + sx32(st.lh);

    // Butterfly scales the old results before the add/subtract
    always_comb begin
        if (st.op == butterfly_add_subtract) begin
            term_high = sx32(high_r) >>> FFT_SHIFT;
            term_low = sx32(low_r) >>> FFT_SHIFT;
        end else begin
            term_high = sx32(high_r);
            term_low = sx32(low_r);
        end
    end

    assign sum_hi = sx16(st.ld_hi) + term_high;
    assign sum_lo = sx16(st.ld_lo) + term_low;
    assign dif_hi = sx16(st.ld_hi) - term_high;
    assign dif_lo = sx16(st.ld_lo) - term_low;

    // Result selection; one operation completes per cycle at most
    always_comb begin
        high_nxt = high_r;
        low_nxt = low_r;
        wr_high = 1'b0;
        wr_low = 1'b0;
        ovf_hit = 1'b0;
        acc = '0;
        case (st.op)
            mul_word: begin
                low_nxt = st.prod[31:0];
                wr_low = 1'b1;
            end
            mul_unsigned_double,
            mul_signed_double: begin
                high_nxt = st.prod[63:32];
                low_nxt = st.prod[31:0];
                wr_high = 1'b1;
                wr_low = 1'b1;
            end
            mac_word: begin
                acc = acc_low + prod_s;
                low_nxt = acc[31:0];
                wr_low = 1'b1;
                ovf_hit = !fits(acc, WORD_W);
            end
            mac_double: begin
                acc = acc_pair + prod_s;
                high_nxt = acc[63:32];
                low_nxt = acc[31:0];
                wr_high = 1'b1;
                wr_low = 1'b1;
                ovf_hit = !fits(acc, DWORD_W);
            end
            msub_word: begin
                acc = acc_low - prod_s;
                low_nxt = acc[31:0];
                wr_low = 1'b1;
                ovf_hit = !fits(acc, WORD_W);
            end
            msub_double: begin
                acc = acc_pair - prod_s;
                high_nxt = acc[63:32];
                low_nxt = acc[31:0];
                wr_high = 1'b1;
                wr_low = 1'b1;
                ovf_hit = !fits(acc, DWORD_W);
            end
            half_mac_word: begin
                acc = acc_low + half_sum;
                low_nxt = acc[31:0];
                wr_low = 1'b1;
                ovf_hit = !fits(acc, WORD_W);
            end
            half_mac_double: begin
                acc = acc_pair + half_sum;
                high_nxt = acc[63:32];
                low_nxt = acc[31:0];
                wr_high = 1'b1;
                wr_low = 1'b1;
                ovf_hit = !fits(acc, DWORD_W);
            end
            complex_multiply: begin
                high_nxt = real_part[31:0];
                low_nxt = imag_part[31:0];
                wr_high = 1'b1;
                wr_low = 1'b1;
                // Only -1 times -1 in both halves can reach this
                ovf_hit = !fits(real_part, WORD_W)
                    || !fits(imag_part, WORD_W);
            end
            complex_multiply_add: begin
                acc = sx32(high_r) + real_part;
                high_nxt = acc[31:0];
                wr_high = 1'b1;
                wr_low = 1'b1;
                ovf_hit = !fits(acc, WORD_W);
                acc = acc_low + imag_part;
                low_nxt = acc[31:0];
                ovf_hit = ovf_hit || !fits(acc, WORD_W);
            end
            complex_add_subtract,
            butterfly_add_subtract: begin
                high_nxt = {sum_hi[15:0], sum_lo[15:0]};
                low_nxt = {dif_hi[15:0], dif_lo[15:0]};
                wr_high = 1'b1;
                wr_low = 1'b1;
                ovf_hit = !fits(sum_hi, HALF_W)
                    || !fits(sum_lo, HALF_W)
                    || !fits(dif_hi, HALF_W)
                    || !fits(dif_lo, HALF_W);
            end
            default: begin
                wr_high = 1'b0;
                wr_low = 1'b0;
            end
        endcase
    end

    // Operands of the butterfly forms come from the destination only;
    // the source product lanes are computed but never read there.

    // High result register. Results land in issue order because the
    // single stage retires one operation per cycle and later ones read
    // the freshly written value on the next cycle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            high_r <= RESULT_RESET;
        end else if (st.valid && wr_high) begin
            high_r <= high_nxt;
        end else if (gwr_high_en) begin
            high_r <= gwr_data;
        end
    end

    // Low result register; the unit owns no condition flag path
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            low_r <= RESULT_RESET;
        end else if (st.valid && wr_low) begin
            low_r <= low_nxt;
        end else if (gwr_low_en) begin
            low_r <= gwr_data;
        end
    end

    // Pending flags cover the cycle before the result is visible.
    // The pipeline waits only when its instruction uses that register.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            low_pending_r <= 1'b0;
        end else begin
            low_pending_r <= issue_valid;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pair_pending_r <= 1'b0;
        end else begin
            pair_pending_r <= issue_valid && writes_high(issue_op);
        end
    end

    // Overflow gating uses the enable sampled at issue
    assign ovf_event = st.valid && ovf_hit && st.ovf_enable;

    // Request stays raised until acknowledged, whether or not further operations issue
    mac_ovf_hold u_ovf_hold (
        .clk(clk),
        .rstn(rstn),
        .ovf_event(ovf_event),
        .ovf_ack(ext_overflow_ack),
        .ovf_req(ext_overflow_req)
    );

    assign high_result_reg = high_r;
    assign low_result_reg = low_r;
    assign low_pending = low_pending_r;
    assign pair_pending = pair_pending_r;
endmodule : dsp_multiply_accumulate_unit
`default_nettype wire

// ---- rtl/mac_ovf_hold.sv ----
`timescale 1ns/1ps
`default_nettype none
module mac_ovf_hold (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Event and handshake
    input wire logic ovf_event,
    input wire logic ovf_ack,
    output logic ovf_req
);
    // Set wins so an overflow in the acknowledge cycle is kept
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ovf_req <= 1'b0;
        end else begin
            ovf_req <= ovf_event | (ovf_req & ~ovf_ack);
        end
    end
endmodule : mac_ovf_hold
`default_nettype wire

// ---- rtl/mac_products.sv ----
`timescale 1ns/1ps
`default_nettype none
module mac_products (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Issue
    input wire logic issue_valid,
    input wire dsp_mac_pkg::dsp_op_type issue_op,
    input wire logic [31:0] dest_operand_reg,
    input wire logic [31:0] src_operand_reg,
    input wire logic ovf_enable,
    // Registered products
    mac_stage_if.producer st
);
    import dsp_mac_pkg::*;

    logic sgn;
    logic signed [32:0] a_ext;
    logic signed [32:0] b_ext;
    logic signed [65:0] p_full;

    // Only the unsigned double multiply zero-extends
    assign sgn = (issue_op != mul_unsigned_double);
    assign a_ext = {sgn & dest_operand_reg[31], dest_operand_reg};
    assign b_ext = {sgn & src_operand_reg[31], src_operand_reg};
    assign p_full = a_ext * b_ext;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st.valid <= 1'b0;
        end else begin
            st.valid <= issue_valid;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st.op <= mul_word;
            st.ld_hi <= 16'h0000;
            st.ld_lo <= 16'h0000;
            st.prod <= 64'h0000_0000_0000_0000;
            st.hh <= 32'h0000_0000;
            st.ll <= 32'h0000_0000;
            st.hl <= 32'h0000_0000;
            st.lh <= 32'h0000_0000;
            st.ovf_enable <= 1'b0;
        end else if (issue_valid) begin
            st.op <= issue_op;
            st.ld_hi <= dest_operand_reg[31:16];
            st.ld_lo <= dest_operand_reg[15:0];
            st.prod <= p_full[63:0];
            st.hh <= $signed(dest_operand_reg[31:16])
                * $signed(src_operand_reg[31:16]);
            st.ll <= $signed(dest_operand_reg[15:0])
                * $signed(src_operand_reg[15:0]);
            st.hl <= $signed(dest_operand_reg[31:16])
                * $signed(src_operand_reg[15:0]);
            st.lh <= $signed(dest_operand_reg[15:0])
                * $signed(src_operand_reg[31:16]);
            st.ovf_enable <= ovf_enable;
        end
    end
endmodule : mac_products
`default_nettype wire

// ---- tb/dsp_mac_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsp_mac_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Issue side
    input wire logic issue_valid,
    input wire dsp_mac_pkg::dsp_op_type issue_op,
    input wire logic [31:0] dest_operand_reg,
    input wire logic [31:0] src_operand_reg,
    input wire logic [31:0] function_control_reg,
    input wire logic gwr_high_en,
    // Results and status
    input wire logic [31:0] high_result_reg,
    input wire logic [31:0] low_result_reg,
    input wire logic low_pending,
    input wire logic pair_pending,
    input wire logic ext_overflow_req,
    input wire logic ext_overflow_ack
);
    import dsp_mac_pkg::*;
    logic word_op;
    logic [31:0] prod_w;
    logic [63:0] prod_s;
    assign word_op = issue_op inside {mul_word, mac_word, msub_word,
                                      half_mac_word};
    assign prod_w = dest_operand_reg * src_operand_reg;
    assign prod_s = $signed(dest_operand_reg) * $signed(src_operand_reg);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    issue_pend_a: assert property (issue_valid |=> low_pending)
        else $error("low pending missing after issue");
    pair_pend_a: assert property (
        issue_valid && !word_op |=> pair_pending)
        else $error("pair pending missing after double issue");
    idle_pend_a: assert property (
        !issue_valid |=> !low_pending && !pair_pending)
        else $error("pending flag without issue");
    word_high_a: assert property (
        (issue_valid && word_op) ##1 !gwr_high_en
        |=> $stable(high_result_reg))
        else $error("word result touched high register");
    mul_word_a: assert property (issue_valid && issue_op == mul_word
        |=> ##1 low_result_reg == $past(prod_w, 2))
        else $error("word product wrong");
    mul_signed_a: assert property (
        issue_valid && issue_op == mul_signed_double
        |=> ##1 {high_result_reg, low_result_reg} == $past(prod_s, 2))
        else $error("signed double product wrong");
    ovf_hold_a: assert property (ext_overflow_req && !ext_overflow_ack
        |=> ext_overflow_req)
        else $error("overflow request dropped before ack");
    ovf_clear_a: assert property (ext_overflow_req && ext_overflow_ack
        && !low_pending |=> !ext_overflow_req)
        else $error("overflow request kept after ack");
    fcr_mask_a: assert property (
        issue_valid && function_control_reg[FCR_OVF_DISABLE_BIT]
        && !low_pending && !ext_overflow_req |=> ##1 !ext_overflow_req)
        else $error("overflow request while disabled");
endmodule : dsp_mac_monitor
bind dsp_multiply_accumulate_unit dsp_mac_monitor mon (
    .clk(clk), .rstn(rstn), .issue_valid(issue_valid), .issue_op(issue_op),
    .dest_operand_reg(dest_operand_reg), .src_operand_reg(src_operand_reg),
    .function_control_reg(function_control_reg), .gwr_high_en(gwr_high_en),
    .high_result_reg(high_result_reg), .low_result_reg(low_result_reg),
    .low_pending(low_pending), .pair_pending(pair_pending),
    .ext_overflow_req(ext_overflow_req), .ext_overflow_ack(ext_overflow_ack)
);
`default_nettype wire

// ---- tb/dsp_multiply_accumulate_unit_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsp_multiply_accumulate_unit_bench;
    import dsp_mac_pkg::*;
    typedef struct {
        dsp_op_type op;
        logic [31:0] d, s;
        logic f;
        logic [31:0] h0, l0, eh, el;
        logic ov;
    } row_type;
    logic clk, rstn, issue_valid, gwr_high_en, gwr_low_en;
    dsp_op_type issue_op;
    logic [31:0] dest_operand_reg, src_operand_reg, function_control_reg;
    logic [31:0] gwr_data, high_result_reg, low_result_reg;
    logic low_pending, pair_pending, ext_overflow_req, ext_overflow_ack;
    logic [3:0] ack_delay;
    int error_cnt = 0;
    int n_compared = 0;
    row_type rows [17] = '{
        '{mul_word, 32'h12344321, 32'h56788765, 1'b0, 32'h11112222,
          32'h33334444, 32'h11112222, 32'h4B7CE305, 1'b0},
        '{mul_unsigned_double, 32'h12344321, 32'h56788765, 1'b0, 32'h0,
          32'h0, 32'h062620AD, 32'h4B7CE305, 1'b0},
        '{mul_unsigned_double, 32'hFFFFFFFF, 32'h2, 1'b0, 32'h0,
          32'h0, 32'h1, 32'hFFFFFFFE, 1'b0},
        '{mul_signed_double, 32'hFFFFFFFF, 32'h2, 1'b0, 32'h0,
          32'h0, 32'hFFFFFFFF, 32'hFFFFFFFE, 1'b0},
        '{mac_word, 32'h12344321, 32'h56788765, 1'b0, 32'h11112222,
          32'h33334444, 32'h11112222, 32'h7EB02749, 1'b1},
        '{mac_word, 32'h1, 32'h1, 1'b0, 32'h0,
          32'h7FFFFFFF, 32'h0, 32'h80000000, 1'b1},
        '{mac_word, 32'h1, 32'h1, 1'b1, 32'h0,
          32'h7FFFFFFF, 32'h0, 32'h80000000, 1'b0},
        '{mac_double, 32'h1, 32'h1, 1'b0, 32'h0,
          32'hFFFFFFFF, 32'h1, 32'h0, 1'b0},
        '{msub_word, 32'h3, 32'h4, 1'b0, 32'h55555555,
          32'h10, 32'h55555555, 32'h4, 1'b0},
        '{msub_double, 32'h1, 32'h1, 1'b0, 32'h1,
          32'h0, 32'h0, 32'hFFFFFFFF, 1'b0},
        '{half_mac_word, 32'h0002FFFF, 32'h00030002, 1'b0, 32'h0,
          32'h1, 32'h0, 32'h5, 1'b0},
        '{half_mac_double, 32'h80008000, 32'h80008000, 1'b0, 32'h0,
          32'h0, 32'h0, 32'h80000000, 1'b0},
        '{complex_multiply, 32'h12344321, 32'h56788765, 1'b0, 32'h0,
          32'h0, 32'h25C61D5B, 32'h0E1927FC, 1'b0},
        '{complex_multiply, 32'h80008000, 32'h80008000, 1'b0, 32'h0,
          32'h0, 32'h0, 32'h80000000, 1'b1},
        '{complex_multiply_add, 32'h00020003, 32'h00040005, 1'b0, 32'h10,
          32'h20, 32'h9, 32'h36, 1'b0},
        '{complex_add_subtract, 32'h00100020, 32'h00100020, 1'b0, 32'h5,
          32'h3, 32'h00150023, 32'h000B001D, 1'b0},
        '{butterfly_add_subtract, 32'h01000200, 32'h01000200, 1'b0,
          32'h00018000, 32'hFFFF8000, 32'h010301FF,
          32'h00FD0201, 1'b0}
    };

    dsp_multiply_accumulate_unit dut (
        .clk(clk), .rstn(rstn), .issue_valid(issue_valid),
        .issue_op(issue_op), .dest_operand_reg(dest_operand_reg),
        .src_operand_reg(src_operand_reg),
        .function_control_reg(function_control_reg),
        .gwr_high_en(gwr_high_en), .gwr_low_en(gwr_low_en),
        .gwr_data(gwr_data), .high_result_reg(high_result_reg),
        .low_result_reg(low_result_reg), .low_pending(low_pending),
        .pair_pending(pair_pending), .ext_overflow_req(ext_overflow_req),
        .ext_overflow_ack(ext_overflow_ack)
    );
    overflow_ack_model pipe (
        .clk(clk), .rstn(rstn), .ext_overflow_req(ext_overflow_req),
        .ack_delay(ack_delay), .ext_overflow_ack(ext_overflow_ack)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic tick;
        @(posedge clk);
        #2;
    endtask : tick

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic give_verdict;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    task automatic preset(input logic [31:0] h, input logic [31:0] l);
        gwr_high_en = 1'b1;
        gwr_data = h;
        tick;
        gwr_high_en = 1'b0;
        gwr_low_en = 1'b1;
        gwr_data = l;
        tick;
        gwr_low_en = 1'b0;
    endtask : preset

    task automatic issue(input dsp_op_type op, input logic [31:0] d,
                         input logic [31:0] s);
        issue_valid = 1'b1;
        issue_op = op;
        dest_operand_reg = d;
        src_operand_reg = s;
        tick;
    endtask : issue

    // Bounded wait for the partner to clear a request
    task automatic wait_idle;
        for (int i = 0; i < 20 && ext_overflow_req !== 1'b0; i++) begin
            tick;
        end
        if (ext_overflow_req !== 1'b0) begin
            error_cnt++;
            give_verdict;
        end
    endtask : wait_idle

    initial begin
        logic pr;
        rstn = 1'b0;
        issue_valid = 1'b0;
        issue_op = mul_word;
        dest_operand_reg = 32'h0;
        src_operand_reg = 32'h0;
        function_control_reg = 32'h0;
        gwr_high_en = 1'b0;
        gwr_low_en = 1'b0;
        gwr_data = 32'h0;
        ack_delay = 4'h0;
        repeat (16) @(posedge clk);
        #2;
        rstn = 1'b1;
        foreach (rows[i]) begin
            function_control_reg = {15'h0, rows[i].f, 16'h0};
            preset(rows[i].h0, rows[i].l0);
            issue(rows[i].op, rows[i].d, rows[i].s);
            issue_valid = 1'b0;
            pr = !(rows[i].op inside {mul_word, mac_word, msub_word,
                                      half_mac_word});
            chk("low_pending", 32'h1, {31'h0, low_pending});
            chk("pair_pending", {31'h0, pr}, {31'h0, pair_pending});
            tick;
            chk("high_result_reg", rows[i].eh, high_result_reg);
            chk("low_result_reg", rows[i].el, low_result_reg);
            chk("ext_overflow_req", {31'h0, rows[i].ov},
                {31'h0, ext_overflow_req});
            wait_idle;
        end
        // Second op accumulates on the first; register write loses
        function_control_reg = 32'h0;
        preset(32'h0, 32'h0);
        issue(mac_word, 32'h2, 32'h3);
        gwr_low_en = 1'b1;
        gwr_data = 32'hDEADBEEF;
        issue(mac_word, 32'h4, 32'h5);
        gwr_low_en = 1'b0;
        issue_valid = 1'b0;
        chk("low_pending", 32'h1, {31'h0, low_pending});
        tick;
        chk("low_result_reg", 32'h0000001A, low_result_reg);
        // Slow ack; issue goes on and enable is taken at issue time
        ack_delay = 4'h4;
        preset(32'h0, 32'h7FFFFFFF);
        issue(mac_word, 32'h1, 32'h1);
        function_control_reg = 32'h00010000;
        issue(mul_word, 32'h3, 32'h5);
        issue_valid = 1'b0;
        tick;
        chk("ext_overflow_req", 32'h1, {31'h0, ext_overflow_req});
        chk("low_result_reg", 32'hF, low_result_reg);
        tick;
        tick;
        chk("ext_overflow_req", 32'h1, {31'h0, ext_overflow_req});
        wait_idle;
        // Reset while an op is pending
        issue(mul_unsigned_double, 32'hFFFFFFFF, 32'h2);
        issue(mac_double, 32'h1, 32'h1);
        issue_valid = 1'b0;
        rstn = 1'b0;
        #2;
        chk("high_result_reg", 32'h0, high_result_reg);
        chk("low_result_reg", 32'h0, low_result_reg);
        chk("low_pending", 32'h0, {31'h0, low_pending});
        tick;
        rstn = 1'b1;
        tick;
        // Nothing may retire after release
        chk("low_result_reg", 32'h0, low_result_reg);
        chk("pair_pending", 32'h0, {31'h0, pair_pending});
        chk("ext_overflow_req", 32'h0, {31'h0, ext_overflow_req});
        give_verdict;
    end
endmodule : dsp_multiply_accumulate_unit_bench
`default_nettype wire

// ---- tb/overflow_ack_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module overflow_ack_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Request and answer
    input wire logic ext_overflow_req,
    input wire logic [3:0] ack_delay,
    output logic ext_overflow_ack
);
    logic [3:0] wait_r;
    // One ack pulse per request, late enough to see the request held
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_r <= 4'h0;
            ext_overflow_ack <= 1'b0;
        end else if (ext_overflow_req && !ext_overflow_ack) begin
            if (wait_r == ack_delay) begin
                ext_overflow_ack <= 1'b1;
                wait_r <= 4'h0;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end else begin
            ext_overflow_ack <= 1'b0;
            wait_r <= 4'h0;
        end
    end
endmodule : overflow_ack_model
`default_nettype wire
